/* hdl/zts_pkg.sv */
/*
  Package for the zero-test skip and table read execution block.
  Assumes a single 125 MHz clock domain; no registers reached by software.
*/
package zts_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned BIT_SEL_W  = 3;
  localparam int unsigned PC_W       = 12;
  localparam int unsigned TBL_W      = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned PAGE_W     = PC_W - TBL_W;
  localparam int unsigned DMEM_DEPTH = 256;

  localparam logic [PAGE_W-1:0] LAST_PAGE  = 4'hf;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] TABLE_HIGH_LATCH_RESET = 8'h00;

  // Instruction group being executed
  typedef enum logic [2:0] {
    ZTS_OP_NONE,
    ZTS_OP_SKIP_BYTE,
    ZTS_OP_MOVE_SKIP,
    ZTS_OP_SKIP_BIT,
    ZTS_OP_TBL_CUR,
    ZTS_OP_TBL_LAST
  } zts_op_t;

  // Decoded instruction from the front end
  typedef struct packed {
    zts_op_t              op;
    logic [ADDR_W-1:0]    addr;
    logic [BIT_SEL_W-1:0] bit_sel;
  } zts_instr_t;

  // Per-cycle execution result
  typedef struct packed {
    logic              flush;
    logic              acc_we;
    logic              table_high_latch_we;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
  } zts_result_t;

endpackage : zts_pkg

/* hdl/zts_dmem.sv */
/*
  Data memory for the execution block: one write port, one read port,
  read data registered. Assumes the caller allows one cycle of read latency.
*/
`timescale 1ns/100ps
module zts_dmem (
  // Clock
  input  wire logic                          clk,
  // Write port
  input  wire logic                          we,
  input  wire logic [zts_pkg::ADDR_W-1:0]    waddr,
  input  wire logic [zts_pkg::DATA_W-1:0]    wdata,
  // Read port
  input  wire logic [zts_pkg::ADDR_W-1:0]    raddr,
  output logic      [zts_pkg::DATA_W-1:0]    rdata
);
  logic [zts_pkg::DATA_W-1:0] mem [zts_pkg::DMEM_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : zts_dmem

/* hdl/zts_exec.sv */
/*
  Execution of byte-zero skip, move-and-skip, bit-zero skip and table reads.
  Assumes the front end holds instr_valid one cycle per instruction, waits
  while busy is high, and returns the program word one cycle after prog_req.
*/
// Summary of operation
// RULE1 - Byte-zero skip with zero byte flushes next instruction, dummy cycle, byte unchanged.
// RULE2 - Move-and-skip always loads accumulator with the byte; source byte unchanged.
// RULE3 - Move-and-skip of zero flushes prefetched instruction; two machine cycles total.
// RULE4 - Nonzero tested value: no flush, skip instruction takes one machine cycle.
// RULE5 - Bit-zero skip tests selected bit; zero bit flushes and inserts dummy cycle.
// RULE6 - Table read: word at pointer, current or last page; low to memory, high to latch.
`timescale 1ns/100ps
module zts_exec (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           resetn,
  // Instruction in
  input  wire logic                           instr_valid,
  input  wire zts_pkg::zts_instr_t            instr,
  input  wire logic [zts_pkg::PC_W-1:0]       pc,
  input  wire logic [zts_pkg::TBL_W-1:0]      tbl_ptr,
  // Program memory
  output logic                                prog_req,
  output logic      [zts_pkg::PC_W-1:0]       prog_addr,
  input  wire logic [zts_pkg::WORD_W-1:0]     prog_data,
  // Core state out
  output logic                                busy,
  output logic                                flush,
  output logic                                dummy_cycle,
  output logic      [zts_pkg::DATA_W-1:0]     acc,
  output logic      [zts_pkg::DATA_W-1:0]     table_high_latch,
  output logic                                dmem_we,
  output logic      [zts_pkg::ADDR_W-1:0]     dmem_waddr,
  output logic      [zts_pkg::DATA_W-1:0]     dmem_wdata
);
  typedef enum logic [1:0] {ZTS_IDLE, ZTS_READ, ZTS_DUMMY} zts_state_t;

  zts_state_t                  state_q, state_d;
  zts_pkg::zts_instr_t         cur_q;
  logic [zts_pkg::DATA_W-1:0]  acc_q;
  logic [zts_pkg::DATA_W-1:0]  table_high_latch_q;
  logic [zts_pkg::DATA_W-1:0]  rdata;
  logic [zts_pkg::DATA_W-1:0]  fwd_data_q;
  logic                        fwd_q;
  logic                        flush_q;
  logic                        dummy_q;
  logic                        busy_q;
  logic                        req_q;
  logic                        we_q;
  logic [zts_pkg::PC_W-1:0]    paddr_q;
  logic [zts_pkg::ADDR_W-1:0]  waddr_q;
  logic [zts_pkg::DATA_W-1:0]  wdata_q;

  function automatic logic is_tbl(input zts_pkg::zts_op_t op);
    return op == zts_pkg::ZTS_OP_TBL_CUR || op == zts_pkg::ZTS_OP_TBL_LAST;
  endfunction : is_tbl

  // Memory write from table read only; skip group never writes back
  zts_dmem u_dmem (
    .clk   (clk),
    .we    (we_q),
    .waddr (waddr_q),
    .wdata (wdata_q),
    .raddr (instr.addr),
    .rdata (rdata)
  );

  // Refused while not idle; the front end holds instr until the read edge
  wire logic take      = instr_valid && (state_q == ZTS_IDLE)
                         && (instr.op != zts_pkg::ZTS_OP_NONE);
  wire logic in_read   = state_q == ZTS_READ;
  // A table write lands on the edge that reads the next byte; use the written byte then
  wire logic [zts_pkg::DATA_W-1:0] mem_byte = fwd_q ? fwd_data_q : rdata;
  wire logic byte_zero = mem_byte == zts_pkg::ZERO_BYTE;
  wire logic bit_zero  = !mem_byte[cur_q.bit_sel];
  wire logic skip_hit  =
    in_read && (((cur_q.op == zts_pkg::ZTS_OP_SKIP_BYTE) && byte_zero)   // RULE1
             || ((cur_q.op == zts_pkg::ZTS_OP_MOVE_SKIP) && byte_zero)   // RULE3
             || ((cur_q.op == zts_pkg::ZTS_OP_SKIP_BIT)  && bit_zero));  // RULE5
  wire logic acc_load  = in_read && (cur_q.op == zts_pkg::ZTS_OP_MOVE_SKIP); // RULE2
  wire logic tbl_done  = in_read && is_tbl(cur_q.op);
  // Page select: current page from pc, or the fixed last page
  wire logic [zts_pkg::PAGE_W-1:0] page =
    (instr.op == zts_pkg::ZTS_OP_TBL_LAST) ? zts_pkg::LAST_PAGE
                                          : pc[zts_pkg::PC_W-1 -: zts_pkg::PAGE_W]; // RULE6

  // A hit costs one dummy cycle; a miss returns to idle at once
  always_comb begin
    state_d = state_q;
    case (state_q)
      ZTS_IDLE:  if (take) state_d = ZTS_READ;
      ZTS_READ:  state_d = skip_hit ? ZTS_DUMMY : ZTS_IDLE; // RULE4
      ZTS_DUMMY: state_d = ZTS_IDLE;
      default:   state_d = ZTS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ZTS_IDLE;
      cur_q   <= '0;
      flush_q <= 1'b0;
      dummy_q <= 1'b0;
      busy_q  <= 1'b0;
      req_q   <= 1'b0;
      paddr_q <= '0;
    end else begin
      state_q <= state_d;
      if (take) cur_q <= instr;
      flush_q <= skip_hit;                  // RULE1
      dummy_q <= skip_hit;                  // RULE3
      busy_q  <= (state_d != ZTS_IDLE);
      req_q   <= take && is_tbl(instr.op);
      if (take) paddr_q <= {page, tbl_ptr}; // RULE6
    end
  end

  // Accumulator and table latch; no status flags touched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q   <= zts_pkg::ACC_RESET;
      table_high_latch_q  <= zts_pkg::TABLE_HIGH_LATCH_RESET;
      we_q    <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
    end else begin
      if (acc_load) acc_q <= mem_byte;                                 // RULE2
      if (tbl_done) table_high_latch_q <= prog_data[zts_pkg::WORD_W-1 -: zts_pkg::DATA_W]; // RULE6
      we_q    <= tbl_done;
      waddr_q <= cur_q.addr;
      wdata_q <= prog_data[zts_pkg::DATA_W-1:0];                      // RULE6
    end
  end

  // Bypass for a read that meets the table write on one edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fwd_q      <= 1'b0;
      fwd_data_q <= zts_pkg::ZERO_BYTE;
    end else begin
      fwd_q      <= we_q && (waddr_q == instr.addr);
      fwd_data_q <= wdata_q;
    end
  end

  assign prog_req         = req_q;
  assign prog_addr        = paddr_q;
  assign busy             = busy_q;
  assign flush            = flush_q;
  assign dummy_cycle      = dummy_q;
  assign acc              = acc_q;
  assign table_high_latch = table_high_latch_q;
  assign dmem_we          = we_q;
  assign dmem_waddr       = waddr_q;
  assign dmem_wdata       = wdata_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Skip group
  a_byte_zero_flush: assert property (in_read && cur_q.op == zts_pkg::ZTS_OP_SKIP_BYTE // RULE1
      && byte_zero |=> flush && dummy_cycle) else $error("zero byte did not flush");
  a_skip_no_write: assert property (in_read && !is_tbl(cur_q.op) |=> !dmem_we) // RULE1
      else $error("skip instruction wrote memory");
  a_skip_no_req: assert property (take && !is_tbl(instr.op) |=> !prog_req) // RULE1
      else $error("skip instruction read program memory");
  a_flush_single: assert property (flush |=> !flush) // RULE1
      else $error("flush held longer than one cycle");
  a_move_acc_load: assert property (acc_load |=> acc == $past(mem_byte)) // RULE2
      else $error("accumulator not loaded");
  a_acc_hold: assert property (!acc_load |=> $stable(acc)) // RULE2
      else $error("accumulator changed without a move");
  a_move_two_cyc: assert property (in_read && cur_q.op == zts_pkg::ZTS_OP_MOVE_SKIP // RULE3
      && byte_zero |=> state_q == ZTS_DUMMY ##1 state_q == ZTS_IDLE)
      else $error("move skip not two cycles");
  a_dummy_to_idle: assert property (state_q == ZTS_DUMMY |=> state_q == ZTS_IDLE) // RULE3
      else $error("dummy cycle not followed by idle");
  a_busy_on_take: assert property (take |=> busy) // RULE3
      else $error("busy not raised on take");
  a_nonzero_one_cyc: assert property (in_read && !skip_hit |=> !flush && state_q == ZTS_IDLE) // RULE4
      else $error("nonzero test flushed");
  a_move_nonzero: assert property (acc_load && !byte_zero |=> !flush && !dummy_cycle) // RULE4
      else $error("nonzero move flushed");
  a_take_to_read: assert property (take |=> state_q == ZTS_READ) // RULE4
      else $error("taken instruction not executed");
  a_dummy_with_flush: assert property (dummy_cycle == flush) // RULE5
      else $error("dummy cycle and flush disagree");
  a_bit_zero_flush: assert property (in_read && cur_q.op == zts_pkg::ZTS_OP_SKIP_BIT // RULE5
      && !mem_byte[cur_q.bit_sel] |=> flush) else $error("zero bit did not flush");
  a_bit_one_pass: assert property (in_read && cur_q.op == zts_pkg::ZTS_OP_SKIP_BIT // RULE5
      && mem_byte[cur_q.bit_sel] |=> !flush) else $error("set bit flushed");

  // Table reads
  a_tbl_last_page: assert property (take && instr.op == zts_pkg::ZTS_OP_TBL_LAST // RULE6
      |=> prog_addr[zts_pkg::PC_W-1 -: zts_pkg::PAGE_W] == zts_pkg::LAST_PAGE)
      else $error("last page not selected");
  a_tbl_cur_page: assert property (take && instr.op == zts_pkg::ZTS_OP_TBL_CUR // RULE6
      |=> prog_addr[zts_pkg::PC_W-1 -: zts_pkg::PAGE_W]
          == $past(pc[zts_pkg::PC_W-1 -: zts_pkg::PAGE_W]))
      else $error("current page not selected");
  a_tbl_ptr_low: assert property (take && is_tbl(instr.op) |=> prog_req // RULE6
      && prog_addr[zts_pkg::TBL_W-1:0] == $past(tbl_ptr)) else $error("table pointer not used");
  a_tbl_low_write: assert property (tbl_done |=> dmem_we // RULE6
      && dmem_wdata == $past(prog_data[zts_pkg::DATA_W-1:0])
      && dmem_waddr == $past(cur_q.addr)
      && table_high_latch == $past(prog_data[zts_pkg::WORD_W-1 -: zts_pkg::DATA_W]))
      else $error("table bytes misrouted");
  a_table_high_latch_hold: assert property (!tbl_done |=> $stable(table_high_latch)) // RULE6
      else $error("table latch changed without a read");
  a_tbl_no_flush: assert property (tbl_done |=> !flush) // RULE6
      else $error("table read flushed");
  a_req_pulse: assert property (prog_req |=> !prog_req) // RULE6
      else $error("program request held too long");
  a_idle_no_req: assert property (!take |=> !prog_req) // RULE6
      else $error("program request without a table read");
  a_we_pulse: assert property (dmem_we |=> !dmem_we) // RULE6
      else $error("memory write held too long");

  // Main scenarios
  c_byte_skip: cover property (in_read && cur_q.op == zts_pkg::ZTS_OP_SKIP_BYTE && skip_hit);
  c_move_noskip: cover property (acc_load && !skip_hit);
  c_bit_skip: cover property (in_read && cur_q.op == zts_pkg::ZTS_OP_SKIP_BIT && skip_hit);
  c_tbl_read: cover property (tbl_done);
  c_fwd_read: cover property (in_read && fwd_q);
endmodule : zts_exec

/* verif/zts_exec_tb.sv */
/*
  Self-checking bench for zts_exec: table reads fill data memory, then the
  three skip kinds run against it. Assumes the word is taken the cycle after prog_req.
*/
`timescale 1ns/100ps
module zts_exec_tb;
  typedef struct {
    logic        fl, rq, we;
    logic [7:0]  acc, th, wa, wd;
    logic [11:0] pa;
    int          due;
  } zts_note_t;

  logic                clk, resetn, instr_valid, prog_req, busy, flush, dummy_cycle, dmem_we;
  zts_pkg::zts_instr_t instr;
  logic [11:0]         pc, prog_addr;
  logic [7:0]          tbl_ptr, acc, table_high_latch, dmem_waddr, dmem_wdata, acc_m, th_m;
  logic [15:0]         prog_data;
  logic [7:0]          mem [256];
  zts_note_t           q[$];
  zts_note_t           m;
  int                  cyc, next_ok, bad_count, n_checks;

  // Pointer 5a gives a zero low byte, so zero values are reachable;
  // the word stands only in the cycle after the request
  always @(negedge clk)
    prog_data <= prog_req ? {prog_addr[11:8], prog_addr[3:0], prog_addr[7:0] ^ 8'h5a} : '0;

  zts_exec DUT (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
    .pc(pc), .tbl_ptr(tbl_ptr), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_data(prog_data), .busy(busy), .flush(flush), .dummy_cycle(dummy_cycle),
    .acc(acc), .table_high_latch(table_high_latch), .dmem_we(dmem_we),
    .dmem_waddr(dmem_waddr), .dmem_wdata(dmem_wdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Issued at the earliest edge the pacing allows, so back-to-back is exercised
  task automatic run(input zts_pkg::zts_op_t op, input logic [7:0] a,
                     input logic [2:0] b, input logic [11:0] p, input logic [7:0] t);
    zts_note_t n;
    logic      tbl;
    while (cyc + 1 < next_ok) @(negedge clk);
    tbl = op inside {zts_pkg::ZTS_OP_TBL_CUR, zts_pkg::ZTS_OP_TBL_LAST};
    n.pa = {(op == zts_pkg::ZTS_OP_TBL_LAST) ? zts_pkg::LAST_PAGE : p[11:8], t};
    n.fl = (op == zts_pkg::ZTS_OP_SKIP_BIT) ? !mem[a][b] : !tbl && mem[a] == 8'h00;
    if (op == zts_pkg::ZTS_OP_MOVE_SKIP)
      acc_m = mem[a];
    if (tbl) begin
      mem[a] = n.pa[7:0] ^ 8'h5a;
      th_m = {n.pa[11:8], n.pa[3:0]};
    end
    n.rq = tbl;
    n.we = tbl;
    n.acc = acc_m;
    n.th = th_m;
    n.wa = a;
    n.wd = mem[a];
    n.due = cyc + 2;
    instr = '{op, a, b};
    pc = p;
    tbl_ptr = t;
    instr_valid = 1'b1;
    q.push_back(n);
    next_ok = cyc + (n.fl ? 4 : 3);
    @(negedge clk);
    instr_valid = 1'b0;
  endtask : run

  always @(negedge clk) begin
    if (q.size() > 0 && cyc == q[0].due - 1) begin
      check(busy, 1'b1);
      check(prog_req, q[0].rq);
      if (q[0].rq)
        check(prog_addr, q[0].pa);
    end
    if (q.size() > 0 && cyc == q[0].due) begin
      m = q.pop_front();
      check(busy, m.fl);
      check(flush, m.fl);
      check(dummy_cycle, m.fl);
      check(acc, m.acc);
      check(table_high_latch, m.th);
      check(dmem_we, m.we);
      if (m.we)
        check({dmem_waddr, dmem_wdata[3:0]}, {m.wa, m.wd[3:0]});
      if (m.we)
        check(dmem_wdata, m.wd);
    end else begin
      check(flush, 1'b0);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    pc = 12'h000;
    tbl_ptr = 8'h00;
    cyc = 0;
    next_ok = 0;
    bad_count = 0;
    n_checks = 0;
    acc_m = zts_pkg::ACC_RESET;
    th_m = zts_pkg::TABLE_HIGH_LATCH_RESET;
    void'($urandom(32'h4b541672));
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    run(zts_pkg::ZTS_OP_TBL_CUR, 8'h10, 3'h0, 12'h3a7, 8'h5a);
    run(zts_pkg::ZTS_OP_TBL_LAST, 8'h11, 3'h0, 12'h3a7, 8'h5b);
    run(zts_pkg::ZTS_OP_TBL_CUR, 8'h12, 3'h0, 12'h5a7, 8'hda);
    for (int i = 0; i < 8; i++)
      run(zts_pkg::zts_op_t'(3'($urandom_range(5, 4))), 8'(8'h20 + i), 3'h0,
          12'($urandom), 8'($urandom));
    $display("table reads done");
    run(zts_pkg::ZTS_OP_SKIP_BYTE, 8'h10, 3'h0, 12'h000, 8'h00);
    run(zts_pkg::ZTS_OP_SKIP_BYTE, 8'h11, 3'h0, 12'h000, 8'h00);
    run(zts_pkg::ZTS_OP_MOVE_SKIP, 8'h11, 3'h0, 12'h000, 8'h00);
    run(zts_pkg::ZTS_OP_MOVE_SKIP, 8'h10, 3'h0, 12'h000, 8'h00);
    run(zts_pkg::ZTS_OP_MOVE_SKIP, 8'h12, 3'h0, 12'h000, 8'h00);
    // Reads right behind the table write of the same byte
    run(zts_pkg::ZTS_OP_TBL_CUR, 8'h13, 3'h0, 12'h6a7, 8'h5a);
    run(zts_pkg::ZTS_OP_SKIP_BYTE, 8'h13, 3'h0, 12'h000, 8'h00);
    run(zts_pkg::ZTS_OP_TBL_LAST, 8'h14, 3'h0, 12'h6a7, 8'h5b);
    run(zts_pkg::ZTS_OP_MOVE_SKIP, 8'h14, 3'h0, 12'h000, 8'h00);
    $display("byte skips and moves done");
    for (int i = 0; i < 8; i++)
      run(zts_pkg::ZTS_OP_SKIP_BIT, 8'h12, 3'(i), 12'h000, 8'h00);
    for (int i = 0; i < 12; i++)
      run(zts_pkg::zts_op_t'(3'($urandom_range(3, 1))), 8'(8'h20 + $urandom_range(7, 0)),
          3'($urandom), 12'h000, 8'h00);
    $display("bit and random skips done");
    repeat (4) @(negedge clk);
    check(12'(q.size()), 12'h000);
    stop_test();
  end
endmodule : zts_exec_tb
